/* rtl/fault_report_pkg.sv */
package fault_report_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] REG_SWITCH = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h01;
    localparam logic [7:0] REG_LOCKUP = 8'h03;
    localparam logic [7:0] REG_CAP_FIRST = 8'h04;
    localparam logic [7:0] REG_CAP_SECOND = 8'h05;
    localparam logic [7:0] REG_STUCK = 8'h06;
    // configuration field positions
    localparam int IRQ_ENABLE_BIT = 0;
    localparam int IRQ_TIMED_RELEASE_BIT = 2;
    localparam int LOCKUP_LATCH_BIT = 3;
    localparam int KEEP_CONNECTED_BIT = 4;
    localparam int LOCKUP_DETECT_DISABLE_BIT = 5;
    localparam int PRECONNECT_TEST_ENABLE_BIT = 7;
    // reset values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] SWITCH_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int IRQ_RELEASE_MS = 2000;
    localparam int IRQ_RELEASE_CYCLES = IRQ_RELEASE_MS * CLK_MHZ * 1000;
    localparam int RESET_MIN_LOW_WIDTH_NS = 500;
    localparam int RESET_MIN_LOW_CYCLES = (RESET_MIN_LOW_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int BITS_PER_FRAME = 9;
    // capture phases after a start condition
    typedef enum logic [3:0] {
        CAP_IDLE = 4'b0001,
        CAP_FIRST = 4'b0010,
        CAP_SECOND = 4'b0100,
        CAP_DONE = 4'b1000
    } cap_state_t;
endpackage

/* rtl/i2c_switch_fault_report.sv */
// Operation
// - read of lock-up flags releases interrupt pin
// - latch option holds lock-up flags until read
// - unconnected channels detected like connected ones
// - keep connections when lock-ups only unconnected
// - capture first two bytes after start
// - freeze capture on lock-up detection
// - reading second capture byte unfreezes it
// - stuck-high bit n blocks channel n while preconnect test is off
// - stuck-high read clears and releases pin
// - preconnect test on each newly selected channel
// - reset-only variant: reset fsm, deselect all
// - pin low long enough resets all but the synchronizers, pin filter and read data
// - own interrupt low is not a reset
// - interrupt driven only when enabled
// - read-release mode holds until lock-up or stuck-high read
// - timed mode releases after fixed timeout
// - new lock-up reasserts after timed release
// - interrupt never triggers own reset
// - lock-up bit n shows channel n
// - detect-disable bit suppresses lock-up detection
`timescale 1ns/1ns
module i2c_switch_fault_report #(
    parameter int IRQ_RELEASE_COUNT = fault_report_pkg::IRQ_RELEASE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // monitored main bus lines
    input wire logic busScl,
    input wire logic busSda,
    // shared reset/interrupt pin
    input wire logic rstIntIn,
    output logic rstIntOut,
    output logic rstIntOe,
    // lock-up timer and preconnect tester
    input wire logic [7:0] lockupRaw,
    output logic [7:0] testRequest,
    input wire logic testDone,
    input wire logic [7:0] testFail,
    // switch and serial engine control
    output logic [7:0] channelConnect,
    output logic serialReset
);
    import fault_report_pkg::*;

    function automatic logic rising(input logic now, input logic prev);
        rising = now & ~prev;
    endfunction

    logic [1:0] sclSync_ff, sdaSync_ff, pinSync_ff;
    logic sclPrev_ff, sdaPrev_ff;
    logic [7:0] config_ff, switch_ff, lockFlags_ff, lockPrev_ff, stuck_ff;
    logic [7:0] connect_ff, pending_ff, testReq_ff, rdData_ff;
    logic [7:0] capFirst_ff, capSecond_ff, shift_ff;
    logic [3:0] bitCnt_ff;
    logic frozen_ff, irqActive_ff, pinRst_ff, serialRst_ff;
    logic [15:0] lowCnt_ff;
    logic [31:0] relCnt_ff;
    cap_state_t capState_ff;

    logic [7:0] lockDet, newLock;
    logic rdLock, rdStuck, rdCapSecond, sclRise, startSeen, irqEvent, relDone;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclSync_ff <= 2'h3;
            sdaSync_ff <= 2'h3;
            pinSync_ff <= 2'h3;
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end else begin
            sclSync_ff <= {sclSync_ff[0], busScl};
            sdaSync_ff <= {sdaSync_ff[0], busSda};
            pinSync_ff <= {pinSync_ff[0], rstIntIn};
            sclPrev_ff <= sclSync_ff[1];
            sdaPrev_ff <= sdaSync_ff[1];
        end
    end

    assign sclRise = rising(sclSync_ff[1], sclPrev_ff);
    assign startSeen = rising(sdaPrev_ff, sdaSync_ff[1]) & sclSync_ff[1] & sclPrev_ff;
    assign rdLock = regRead && regAddr == REG_LOCKUP;
    assign rdStuck = regRead && regAddr == REG_STUCK;
    assign rdCapSecond = regRead && regAddr == REG_CAP_SECOND;
    assign lockDet = config_ff[LOCKUP_DETECT_DISABLE_BIT] ? 8'h00 : lockupRaw;
    assign newLock = lockDet & ~lockPrev_ff;
    assign irqEvent = (|newLock) | (testDone & (|(pending_ff & testFail)));
    assign relDone = relCnt_ff == 32'(IRQ_RELEASE_COUNT - 1);

    // external reset filter: a low must last the minimum width, own drive masks it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lowCnt_ff <= 16'h0000;
            pinRst_ff <= 1'b0;
        end else if (pinSync_ff[1] || irqActive_ff) begin
            lowCnt_ff <= 16'h0000;
            pinRst_ff <= 1'b0;
        end else if (lowCnt_ff == 16'(RESET_MIN_LOW_CYCLES - 1)) begin
            pinRst_ff <= 1'b1;
        end else begin
            lowCnt_ff <= lowCnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            serialRst_ff <= 1'b1;
        end else begin
            serialRst_ff <= pinRst_ff;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            config_ff <= CONFIG_RESET;
            switch_ff <= SWITCH_RESET;
        end else if (pinRst_ff) begin
            config_ff <= CONFIG_RESET;
            switch_ff <= SWITCH_RESET;
        end else if (regWrite && regAddr == REG_CONFIG) begin
            config_ff <= regWrData;
        end else if (regWrite && regAddr == REG_SWITCH) begin
            switch_ff <= regWrData;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lockFlags_ff <= FLAGS_RESET;
            lockPrev_ff <= FLAGS_RESET;
        end else if (pinRst_ff) begin
            lockFlags_ff <= FLAGS_RESET;
            lockPrev_ff <= FLAGS_RESET;
        end else begin
            lockPrev_ff <= lockDet;
            if (config_ff[LOCKUP_LATCH_BIT]) begin
                lockFlags_ff <= (rdLock ? 8'h00 : lockFlags_ff) | lockDet;
            end else begin
                lockFlags_ff <= lockDet;
            end
        end
    end

    // connection control with preconnect test and lock-up isolation
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            connect_ff <= SWITCH_RESET;
            pending_ff <= 8'h00;
            testReq_ff <= 8'h00;
        end else if (pinRst_ff) begin
            connect_ff <= SWITCH_RESET;
            pending_ff <= 8'h00;
            testReq_ff <= 8'h00;
        end else begin
            testReq_ff <= 8'h00;
            if (|newLock) begin
                if (config_ff[KEEP_CONNECTED_BIT]) begin
                    connect_ff <= connect_ff & ~lockDet;
                end else begin
                    connect_ff <= 8'h00;
                end
            end else if (regWrite && regAddr == REG_SWITCH) begin
                if (config_ff[PRECONNECT_TEST_ENABLE_BIT]
                        && |(regWrData & ~connect_ff)) begin
                    connect_ff <= regWrData & connect_ff;
                    pending_ff <= regWrData & ~connect_ff;
                    testReq_ff <= regWrData & ~connect_ff;
                end else begin
                    connect_ff <= regWrData & ~stuck_ff;
                end
            end else if (testDone && |pending_ff) begin
                connect_ff <= connect_ff | (pending_ff & ~testFail);
                pending_ff <= 8'h00;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stuck_ff <= FLAGS_RESET;
        end else if (pinRst_ff) begin
            stuck_ff <= FLAGS_RESET;
        end else begin
            // a failure in the read cycle survives the clear
            stuck_ff <= (rdStuck ? 8'h00 : stuck_ff)
                | (testDone ? pending_ff & testFail : 8'h00);
        end
    end

    // interrupt drive and timed release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqActive_ff <= 1'b0;
            relCnt_ff <= 32'h0000_0000;
        end else if (pinRst_ff) begin
            irqActive_ff <= 1'b0;
            relCnt_ff <= 32'h0000_0000;
        end else if (irqEvent && config_ff[IRQ_ENABLE_BIT]) begin
            irqActive_ff <= 1'b1;
            relCnt_ff <= 32'h0000_0000;
        end else if (rdLock || rdStuck) begin
            irqActive_ff <= 1'b0;
        end else if (irqActive_ff && config_ff[IRQ_TIMED_RELEASE_BIT]) begin
            if (relDone) begin
                irqActive_ff <= 1'b0;
            end else begin
                relCnt_ff <= relCnt_ff + 32'h0000_0001;
            end
        end
    end

    // traffic capture after each start condition
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            capState_ff <= CAP_IDLE;
            bitCnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            capFirst_ff <= 8'h00;
            capSecond_ff <= 8'h00;
        end else if (pinRst_ff) begin
            // pin reset clears every capture register, the two captured bytes included
            capState_ff <= CAP_IDLE;
            bitCnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            capFirst_ff <= 8'h00;
            capSecond_ff <= 8'h00;
        end else if (startSeen) begin
            capState_ff <= CAP_FIRST;
            bitCnt_ff <= 4'h0;
        end else if (sclRise) begin
            bitCnt_ff <= (bitCnt_ff == 4'(BITS_PER_FRAME - 1)) ? 4'h0 : bitCnt_ff + 4'h1;
            if (bitCnt_ff < 4'h8) begin
                shift_ff <= {shift_ff[6:0], sdaSync_ff[1]};
            end
            case (capState_ff)
                CAP_FIRST: begin
                    if (bitCnt_ff == 4'h7) begin
                        capState_ff <= CAP_SECOND;
                        if (!frozen_ff) begin
                            capFirst_ff <= {shift_ff[6:0], sdaSync_ff[1]};
                        end
                    end
                end
                CAP_SECOND: begin
                    if (bitCnt_ff == 4'h7) begin
                        capState_ff <= CAP_DONE;
                        if (!frozen_ff) begin
                            capSecond_ff <= {shift_ff[6:0], sdaSync_ff[1]};
                        end
                    end
                end
                CAP_IDLE, CAP_DONE: begin
                    capState_ff <= capState_ff;
                end
                default: begin
                    capState_ff <= CAP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            frozen_ff <= 1'b0;
        end else if (pinRst_ff) begin
            frozen_ff <= 1'b0;
        end else if (|newLock) begin
            frozen_ff <= 1'b1;
        end else if (rdCapSecond) begin
            frozen_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_ff <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                REG_SWITCH: rdData_ff <= switch_ff;
                REG_CONFIG: rdData_ff <= config_ff;
                REG_LOCKUP: rdData_ff <= lockFlags_ff;
                REG_CAP_FIRST: rdData_ff <= capFirst_ff;
                REG_CAP_SECOND: rdData_ff <= capSecond_ff;
                REG_STUCK: rdData_ff <= stuck_ff;
                default: rdData_ff <= 8'h00;
            endcase
        end else begin
            rdData_ff <= 8'h00;
        end
    end

    assign regRdData = rdData_ff;
    assign rstIntOut = 1'b0;
    assign rstIntOe = irqActive_ff;
    assign channelConnect = connect_ff;
    assign testRequest = testReq_ff;
    assign serialReset = serialRst_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_lock_read_release: assert property (
        rdLock && !(irqEvent && config_ff[IRQ_ENABLE_BIT]) |=> !rstIntOe)
        else $error("interrupt still driven after lock-up read");
    a_latch_holds_flag: assert property (
        config_ff[LOCKUP_LATCH_BIT] && lockFlags_ff[0] && !rdLock && !pinRst_ff
        |=> lockFlags_ff[0])
        else $error("latched lock-up flag lost without read");
    a_keep_connected: assert property (
        config_ff[KEEP_CONNECTED_BIT] && |newLock && (lockDet & connect_ff) == 8'h00
        && !pinRst_ff |=> connect_ff == $past(connect_ff))
        else $error("connection dropped for unconnected lock-up");
    a_freeze_capture: assert property (
        frozen_ff && !rdCapSecond && !pinRst_ff |=> $stable(capFirst_ff) && $stable(capSecond_ff))
        else $error("frozen capture changed");
    a_unfreeze_read: assert property (
        rdCapSecond && !(|newLock) && !pinRst_ff |=> !frozen_ff)
        else $error("capture stayed frozen after read");
    a_stuck_blocks: assert property (
        (stuck_ff & connect_ff) == 8'h00 |-> ##1 (($past(stuck_ff) & ~$past(connect_ff)) &
        connect_ff) == 8'h00)
        else $error("stuck channel connected");
    a_stuck_read_clear: assert property (
        rdStuck && !testDone && !pinRst_ff |=> stuck_ff == 8'h00)
        else $error("stuck register not cleared by read");
    a_own_irq_no_reset: assert property (
        irqActive_ff |=> !pinRst_ff)
        else $error("own interrupt caused a reset");
    a_irq_needs_enable: assert property (
        $rose(irqActive_ff) |-> $past(config_ff[IRQ_ENABLE_BIT]))
        else $error("interrupt without enable");
    a_pin_reset_clears: assert property (
        pinRst_ff |=> connect_ff == 8'h00 && config_ff == CONFIG_RESET && serialReset)
        else $error("pin reset did not clear state");
    a_detect_disable: assert property (
        config_ff[LOCKUP_DETECT_DISABLE_BIT] && !config_ff[LOCKUP_LATCH_BIT]
        |=> lockFlags_ff == 8'h00)
        else $error("lock-up seen while detection disabled");
    a_short_low_ignored: assert property (
        $rose(pinRst_ff) |-> !$past(pinSync_ff[1], RESET_MIN_LOW_CYCLES)
        && !$past(irqActive_ff, RESET_MIN_LOW_CYCLES))
        else $error("reset taken from a short low");

    c_lock_irq: cover property (|newLock && config_ff[IRQ_ENABLE_BIT] ##1 rstIntOe);
    c_timed_release: cover property (rstIntOe && relDone ##1 !rstIntOe);
    c_test_fail: cover property (testDone && |(pending_ff & testFail));
    c_pin_reset: cover property ($rose(pinRst_ff));
endmodule

/* tb/i2c_host_model.sv */
`timescale 1ns/1ns
module i2c_host_model (
    // frame request
    input wire logic go,
    input wire logic [15:0] frameBytes,
    // main bus lines, pulled up when released
    output logic scl,
    output logic sda,
    output logic busy
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        busy = 1'b0;
    end
    // start, two bytes with a released ack slot, stop; clock runs only in frames
    always @(posedge go) begin
        busy = 1'b1;
        sda = 1'b0;
        #62;
        for (int i = 0; i < 18; i++) begin
            scl = 1'b0;
            #31;
            sda = (i == 8 || i == 17) ? 1'b1 : frameBytes[(i < 8) ? 15 - i : 16 - i];
            #31;
            scl = 1'b1;
            #63;
        end
        scl = 1'b0;
        sda = 1'b0;
        #62;
        scl = 1'b1;
        #63;
        sda = 1'b1;
        busy = 1'b0;
    end
endmodule

/* tb/i2c_switch_fault_report_tb_top.sv */
`timescale 1ns/1ns
module i2c_switch_fault_report_tb_top;
    import fault_report_pkg::*;
    logic clk, sys_rst, regWrite, regRead, busScl, busSda, rstIntIn, rstIntOut;
    logic [7:0] regAddr, regWrData, regRdData, lockupRaw, testRequest, testFail;
    logic [7:0] channelConnect;
    logic rstIntOe, hostLow, testDone, serialReset, go, busy;
    logic [15:0] frameBytes;
    int bad_count;
    int n_tests;
    int k;
    // pin is pulled up; low when the device or the host pulls it
    assign rstIntIn = (rstIntOe ? rstIntOut : 1'b1) & ~hostLow;
    i2c_switch_fault_report #(.IRQ_RELEASE_COUNT(20)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .busScl(busScl), .busSda(busSda), .rstIntIn(rstIntIn), .rstIntOut(rstIntOut),
        .rstIntOe(rstIntOe), .lockupRaw(lockupRaw), .testRequest(testRequest),
        .testDone(testDone), .testFail(testFail), .channelConnect(channelConnect),
        .serialReset(serialReset));
    i2c_host_model u_host (.go(go), .frameBytes(frameBytes), .scl(busScl),
        .sda(busSda), .busy(busy));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    task automatic lock(input logic [7:0] v);
        @(posedge clk);
        lockupRaw <= v;
        look(2);
    endtask
    task automatic pin(input int n);
        @(posedge clk);
        hostLow <= 1'b1;
        repeat (n) @(posedge clk);
        hostLow <= 1'b0;
    endtask
    // bounded wait for the interrupt output to reach a level
    task automatic waitOe(input logic v);
        for (k = 0; k < 60 && rstIntOe !== v; k++) look(1);
        chk({7'h00, rstIntOe}, {7'h00, v});
        if (k == 60) give_verdict();
    endtask
    task automatic frame(input logic [15:0] b);
        @(posedge clk);
        frameBytes <= b;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (k = 0; k < 400 && busy !== 1'b0; k++) look(1);
        chk({7'h00, busy}, 8'h00);
        if (k == 400) give_verdict();
    endtask
    task automatic scReset();
        look(1);
        chk({6'h00, serialReset, rstIntOe}, 8'h00);
        chk(channelConnect, SWITCH_RESET);
        rdChk(REG_CONFIG, CONFIG_RESET);
        rdChk(REG_LOCKUP, FLAGS_RESET);
        rdChk(REG_STUCK, FLAGS_RESET);
        wr(REG_LOCKUP, 8'hFF);
        rdChk(REG_LOCKUP, 8'h00);
        rdChk(8'h7F, 8'h00);
    endtask
    task automatic scCaptureIrq();
        frame(16'h6860);
        rdChk(REG_CAP_FIRST, 8'h68);
        rdChk(REG_CAP_SECOND, 8'h60);
        wr(REG_CONFIG, 8'h01);
        wr(REG_SWITCH, 8'h03);
        look(2);
        chk(channelConnect, 8'h03);
        lock(8'h02);
        waitOe(1'b1);
        chk(channelConnect, 8'h00);
        frame(16'h1122);
        rdChk(REG_CAP_FIRST, 8'h68);
        chk({7'h00, rstIntOe}, 8'h01);
        rdChk(REG_CAP_SECOND, 8'h60);
        frame(16'h3344);
        rdChk(REG_CAP_FIRST, 8'h33);
        rdChk(REG_LOCKUP, 8'h02);
        chk({7'h00, rstIntOe}, 8'h00);
        lock(8'h00);
        rdChk(REG_LOCKUP, 8'h00);
    endtask
    task automatic scOptions();
        wr(REG_CONFIG, 8'h00);
        lock(8'h01);
        look(3);
        chk({7'h00, rstIntOe}, 8'h00);
        rdChk(REG_LOCKUP, 8'h01);
        lock(8'h00);
        wr(REG_CONFIG, 8'h20);
        lock(8'h04);
        rdChk(REG_LOCKUP, 8'h00);
        lock(8'h00);
        wr(REG_CONFIG, 8'h08);
        lock(8'h04);
        lock(8'h00);
        rdChk(REG_LOCKUP, 8'h04);
        rdChk(REG_LOCKUP, 8'h00);
        wr(REG_CONFIG, 8'h11);
        wr(REG_SWITCH, 8'h01);
        lock(8'h80);
        waitOe(1'b1);
        chk(channelConnect, 8'h01);
        lock(8'h81);
        look(2);
        chk(channelConnect, 8'h00);
        lock(8'h00);
        rdChk(REG_LOCKUP, 8'h00);
        waitOe(1'b0);
    endtask
    task automatic scTimed();
        wr(REG_CONFIG, 8'h05);
        lock(8'h01);
        waitOe(1'b1);
        waitOe(1'b0);
        chk({7'h00, k >= 15 && k <= 30}, 8'h01);
        lock(8'h03);
        waitOe(1'b1);
        chk({7'h00, k < 4}, 8'h01);
        lock(8'h00);
        rdChk(REG_LOCKUP, 8'h00);
    endtask
    task automatic scPreconnect(input logic [7:0] req);
        wr(REG_SWITCH, 8'h03);
        #1 chk(testRequest, req);
        @(posedge clk);
        testDone <= 1'b1;
        testFail <= 8'h02;
        @(posedge clk);
        testDone <= 1'b0;
        testFail <= 8'h00;
        look(2);
        chk(channelConnect, 8'h01);
        waitOe(1'b1);
        rdChk(REG_STUCK, 8'h02);
        waitOe(1'b0);
        rdChk(REG_STUCK, 8'h00);
    endtask
    task automatic scPin();
        pin(20);
        look(6);
        rdChk(REG_CONFIG, 8'h81);
        lock(8'h01);
        waitOe(1'b1);
        chk({7'h00, rstIntIn}, 8'h00);
        look(70);
        rdChk(REG_CONFIG, 8'h81);
        lock(8'h00);
        rdChk(REG_LOCKUP, 8'h00);
        pin(60);
        #1 chk({7'h00, serialReset}, 8'h01);
        look(6);
        rdChk(REG_CONFIG, CONFIG_RESET);
        chk(channelConnect, 8'h00);
    endtask
    initial begin
        #500000;
        chk(8'h00, 8'h01);
        give_verdict();
    end
    initial begin
        {regWrite, regRead, hostLow, testDone, go} = '0;
        {regAddr, regWrData, lockupRaw, testFail} = '0;
        frameBytes = '0;
        bad_count = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        scReset();
        scCaptureIrq();
        scOptions();
        scTimed();
        wr(REG_CONFIG, 8'h81);
        scPreconnect(8'h03);
        scPreconnect(8'h02);
        scPin();
        give_verdict();
    end
endmodule
